// >>> usart_sync_master_tx_addr_detect.sv
// Behaviour
// - Nine-bit address detect discards words whose ninth bit is zero.
// - Nine-bit address detect loads words with ninth bit one, raising receive flag.
// - Software clears address detect once addressed; then all words load.
// - Receive flag marks a buffered word; interrupt only when its enable set.
// - Synchronous mode is half duplex; transmit and receive exclude each other.
// - Sync select picks synchronous mode; port enable gives pins to the port.
// - Master clock select makes the block drive the shift clock.
// - Shifter reloads only after its last bit, and only from full buffer.
// - Buffer to shifter move takes one cycle, empties buffer, sets transmit flag.
// - Transmit flag ignores its enable and writes; clears on buffer write.
// - Shift register empty bit is read-only status with no interrupt.
// - Transmit enable permits; first bit on next rising clock edge.
// - Baud generator held reset with all enables clear; transmit enable starts it.
// - Buffer loaded before transmit enable starts as soon as enable sets.
// - Write to empty shifter moves at once; words go back to back.
// - Clearing transmit enable aborts, resets transmitter, floats data; clock floats too unless a receive enable is set.
// - Receive enable during transmit floats data; master clock stays; state kept.
// - Single reception clears its enable, then transmission resumes driving data.
// - Ninth transmit bit is captured when the word enters the shifter.
// - Receive buffer is a two-entry FIFO holding ninth bit and framing error.
// - Third word into full FIFO sets overrun, is lost, blocks until cleared.
`timescale 1ns/1ps

`include "usart_params.svh"

module usart_sync_master_tx_addr_detect
	import usart_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	input  wire logic        i_mclk,     // Core clock, 40 MHz.
	input  wire logic        i_rst_n,    // Synchronous reset, active low.
	input  wire logic        i_hsel,     // AHB-Lite slave select.
	input  wire logic [31:0] i_haddr,    // AHB-Lite byte address.
	input  wire logic [1:0]  i_htrans,   // AHB-Lite transfer type.
	input  wire logic        i_hwrite,   // AHB-Lite write strobe.
	input  wire logic [2:0]  i_hsize,    // AHB-Lite size, words only.
	input  wire logic [31:0] i_hwdata,   // AHB-Lite write data.
	input  wire logic        i_hready,   // AHB-Lite bus ready.
	output logic      [31:0] o_hrdata,   // AHB-Lite read data.
	output logic             o_hreadyout, // AHB-Lite slave ready.
	output logic             o_hresp,    // AHB-Lite response, always OKAY.
	input  wire logic        i_rx_valid, // Receiver finished a word, one cycle.
	input  wire logic [7:0]  i_rx_data,  // Received byte.
	input  wire logic        i_rx_bit8,  // Received ninth bit.
	input  wire logic        i_rx_framing_error,  // Received framing error.
	output logic             o_ck,       // Shift clock line output.
	output logic             o_ck_oe,    // Shift clock line drive enable.
	output logic             o_dt,       // Shift data line output.
	output logic             o_dt_oe,    // Shift data line drive enable.
	output logic             o_irq       // Interrupt request, active high.
);

	if (RX_DEPTH != 2) begin : g_depth_check
		$error("Only a two-entry receive FIFO is built.");
	end

	state_t s;
	state_t n;

	logic run;
	logic tick;
	logic master;
	logic rx_en;
	logic rise;
	logic tx_link;
	logic pop;
	logic rx_take;
	logic rx_filt;
	logic wr_tx;

	function automatic logic [7:0] read_mux(input state_t st, input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`IDX_IRQ_FLAGS: begin
				v[`PIR_RX_FLAG] = (st.rx_cnt != 2'h0);
				v[`PIR_TX_FLAG] = st.transmit_flag;
			end
			`IDX_RX_CTRL:  v = {st.serial_port_enable, st.rx9, st.single_receive_enable, st.continuous_receive_enable, st.address_detect_enable,
				st.fifo[0].framing_error, st.overrun_error, st.fifo[0].bit8};
			`IDX_TX_BUF:   v = st.txbuf;
			`IDX_RX_BUF:   v = st.fifo[0].data;
			`IDX_IRQ_EN:   v = st.irq_en;
			`IDX_TX_CTRL:  v = {st.master_clock_select, st.tx9, st.transmit_enable, st.sync, 1'b0, st.high_speed_baud,
				~st.tsr_full, st.transmit_ninth_bit};
			`IDX_BAUD_DIV: v = st.baud_div;
			default:       v = 8'h00;
		endcase
		return v;
	endfunction : read_mux

	assign run     = s.transmit_enable | s.continuous_receive_enable | s.single_receive_enable;
	assign tick    = run && (s.brg_cnt == 8'h00);
	assign master  = s.serial_port_enable & s.sync & s.master_clock_select;
	assign rx_en   = s.continuous_receive_enable | s.single_receive_enable;
	assign rise    = tick & master & ~s.ck;
	assign tx_link = s.serial_port_enable & s.sync & s.transmit_enable & ~rx_en;
	assign pop     = (s.bus == BUS_RD_WAIT) && (s.idx == `IDX_RX_BUF) && (s.rx_cnt != 2'h0);
	assign rx_take = i_rx_valid & s.serial_port_enable & rx_en;
	assign rx_filt = s.rx9 & s.address_detect_enable & ~i_rx_bit8;
	assign wr_tx   = s.wr_pend && (s.idx == `IDX_TX_BUF);

	always_comb begin
		logic [3:0] wbits;
		logic       transmit_flag_set;
		logic [7:0] wd;
		n        = s;
		wbits    = s.tx9 ? `BITS_NINE : `BITS_EIGHT;
		transmit_flag_set = 1'b0;
		wd       = i_hwdata[7:0];

		// Baud generator: one tick per (divisor + 1) cycles, each tick is half a bit.
		if (!run || tick) begin
			n.brg_cnt = s.baud_div;
		end else begin
			n.brg_cnt = s.brg_cnt - 8'h01;
		end
		n.ck = master & run & (tick ? ~s.ck : s.ck);

		// Transmitter.
		if (!s.transmit_enable) begin
			n.tsr_full  = 1'b0;
			n.bits_left = 4'h0;
		end else if (!s.tsr_full) begin
			if (s.txbuf_full) begin
				n.transmit_shifter        = {s.tx9 & s.transmit_ninth_bit, s.txbuf};
				n.bits_left  = wbits;
				n.tsr_full   = 1'b1;
				n.txbuf_full = 1'b0;
				transmit_flag_set     = 1'b1;
			end
		end else if (rise && tx_link) begin
			if (s.bits_left != 4'h0) begin
				n.dt        = s.transmit_shifter[0];
				n.transmit_shifter       = {1'b0, s.transmit_shifter[8:1]};
				n.bits_left = s.bits_left - 4'h1;
			end else if (s.txbuf_full) begin
				// Reload on the edge that ends the last bit, so words leave with no gap.
				n.dt         = s.txbuf[0];
				n.transmit_shifter        = {1'b0, s.tx9 & s.transmit_ninth_bit, s.txbuf[7:1]};
				n.bits_left  = wbits - 4'h1;
				n.txbuf_full = 1'b0;
				transmit_flag_set     = 1'b1;
			end else begin
				n.tsr_full = 1'b0;
			end
		end
		n.dt_oe = tx_link;
		n.ck_oe = master & (s.transmit_enable | rx_en);

		// Receive FIFO, popped by a read of the receive buffer.
		if (pop) begin
			n.fifo[0] = s.fifo[1];
			n.rx_cnt  = s.rx_cnt - 2'h1;
		end
		if (!s.continuous_receive_enable) begin
			n.overrun_error = 1'b0;
		end
		if (rx_take) begin
			if (s.sync && s.single_receive_enable && !s.continuous_receive_enable) begin
				n.single_receive_enable = 1'b0;
			end
			if (!rx_filt && !s.overrun_error) begin
				if (n.rx_cnt == 2'h2) begin
					n.overrun_error = 1'b1;
				end else begin
					n.fifo[n.rx_cnt[0]] = '{framing_error: i_rx_framing_error, bit8: i_rx_bit8, data: i_rx_data};
					n.rx_cnt            = n.rx_cnt + 2'h1;
				end
			end
		end

		// Bus data phase.
		if (s.bus == BUS_RD_WAIT) begin
			n.hrdata = {24'h000000, read_mux(s, s.idx)};
			n.hready = 1'b1;
			n.bus    = BUS_IDLE;
		end
		if (s.wr_pend) begin
			n.wr_pend = 1'b0;
			unique case (s.idx)
				`IDX_RX_CTRL: begin
					n.serial_port_enable  = wd[`RCS_SERIAL_PORT_ENABLE];
					n.rx9   = wd[`RCS_RX9];
					n.single_receive_enable  = wd[`RCS_SINGLE_RECEIVE_ENABLE];
					n.continuous_receive_enable  = wd[`RCS_CONTINUOUS_RECEIVE_ENABLE];
					n.address_detect_enable = wd[`RCS_ADDRESS_DETECT_ENABLE];
				end
				`IDX_TX_BUF: begin
					n.txbuf      = wd;
					n.txbuf_full = 1'b1;
				end
				`IDX_IRQ_EN: n.irq_en = wd;
				`IDX_TX_CTRL: begin
					n.master_clock_select = wd[`TXS_MASTER_CLOCK_SELECT];
					n.tx9  = wd[`TXS_TX9];
					n.transmit_enable = wd[`TXS_TRANSMIT_ENABLE];
					n.sync = wd[`TXS_SYNC];
					n.high_speed_baud = wd[`TXS_HIGH_SPEED_BAUD];
					n.transmit_ninth_bit = wd[`TXS_TRANSMIT_NINTH_BIT];
					if (wd[`TXS_TRANSMIT_ENABLE] && !s.transmit_enable && !s.txbuf_full) begin
						transmit_flag_set = 1'b1;
					end
				end
				`IDX_BAUD_DIV: n.baud_div = wd;
				default: begin
					// Flags, receive buffer and unmapped words ignore writes.
				end
			endcase
		end
		if (transmit_flag_set) begin
			n.transmit_flag = 1'b1;
		end else if (wr_tx) begin
			n.transmit_flag = 1'b0;
		end

		// Bus address phase.
		if (i_hsel && i_htrans[1] && i_hready) begin
			if (i_haddr[31:10] == 22'h000000 && i_haddr[1:0] == 2'h0) begin
				n.idx = i_haddr[9:2];
			end else begin
				n.idx = `IDX_UNMAPPED;
			end
			if (i_hwrite) begin
				n.wr_pend = 1'b1;
			end else begin
				n.bus    = BUS_RD_WAIT;
				n.hready = 1'b0;
			end
		end

		n.irq = ((s.rx_cnt != 2'h0) & s.irq_en[`PIR_RX_FLAG]) |
			(s.transmit_flag & s.irq_en[`PIR_TX_FLAG]);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s        <= '0;
			s.hready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign o_hrdata    = s.hrdata;
	assign o_hreadyout = s.hready;
	assign o_hresp     = 1'b0;
	assign o_ck        = s.ck;
	assign o_ck_oe     = s.ck_oe;
	assign o_dt        = s.dt;
	assign o_dt_oe     = s.dt_oe;
	assign o_irq       = s.irq;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	addr_discard_a: assert property (
		rx_take && rx_filt && !pop |=> s.rx_cnt == $past(s.rx_cnt))
		else $error("Address filter let a data word through.");

	addr_accept_a: assert property (
		rx_take && s.rx9 && s.address_detect_enable && i_rx_bit8 && !s.overrun_error && s.rx_cnt == 2'h0
		|=> s.rx_cnt == 2'h1 ##1 o_irq == s.irq_en[`PIR_RX_FLAG])
		else $error("Address word not loaded or flag not raised.");

	rx_irq_a: assert property (
		s.rx_cnt != 2'h0 && s.irq_en[`PIR_RX_FLAG] |=> o_irq)
		else $error("Receive interrupt missing.");

	tx_load_a: assert property (
		s.transmit_enable && !s.tsr_full && s.txbuf_full |=> s.tsr_full && !s.txbuf_full && s.transmit_flag)
		else $error("Buffer to shifter move wrong.");

	transmit_flag_hold_a: assert property (
		s.transmit_flag && !wr_tx |=> s.transmit_flag)
		else $error("Transmit flag cleared without a buffer write.");

	brg_hold_a: assert property (
		!run |=> s.brg_cnt == $past(s.baud_div))
		else $error("Baud generator not held in reset.");

	shift_edge_a: assert property (
		$changed(o_dt) |-> $past(rise))
		else $error("Data changed away from a rising clock edge.");

	tx_abort_a: assert property (
		!s.transmit_enable && !rx_en |=> !s.tsr_full && !o_dt_oe && !o_ck_oe)
		else $error("Transmitter not reset or lines still driven.");

	rx_float_a: assert property (
		rx_en && master |=> !o_dt_oe && o_ck_oe)
		else $error("Data line driven or clock released during reception.");

	overrun_a: assert property (
		rx_take && !rx_filt && s.continuous_receive_enable && s.rx_cnt == 2'h2 && !pop |=> s.overrun_error && s.rx_cnt == 2'h2)
		else $error("Overrun not flagged.");

	single_receive_enable_clear_a: assert property (
		rx_take && s.sync && s.single_receive_enable && !s.continuous_receive_enable && !s.wr_pend |=> !s.single_receive_enable)
		else $error("Single receive enable not cleared.");

	back_to_back_c: cover property (rise && tx_link && s.bits_left == 4'h0 && s.txbuf_full);
	addr_word_c:    cover property (rx_take && s.address_detect_enable && s.rx9 && i_rx_bit8);
	overrun_c:      cover property (!s.overrun_error ##1 s.overrun_error);
	abort_c:        cover property (s.tsr_full && s.transmit_enable ##1 !s.transmit_enable);

endmodule : usart_sync_master_tx_addr_detect

// >>> usart_params.svh
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH

// Register indices; byte address is four times the index.
`define IDX_IRQ_FLAGS   8'h0c
`define IDX_RX_CTRL     8'h18
`define IDX_TX_BUF      8'h19
`define IDX_RX_BUF      8'h1a
`define IDX_IRQ_EN      8'h8c
`define IDX_TX_CTRL     8'h98
`define IDX_BAUD_DIV    8'h99
`define IDX_UNMAPPED    8'hff

// Field positions.
`define PIR_RX_FLAG     5
`define PIR_TX_FLAG     4
`define RCS_SERIAL_PORT_ENABLE        7
`define RCS_RX9         6
`define RCS_SINGLE_RECEIVE_ENABLE        5
`define RCS_CONTINUOUS_RECEIVE_ENABLE        4
`define RCS_ADDRESS_DETECT_ENABLE       3
`define RCS_FRAMING_ERROR        2
`define RCS_OVERRUN_ERROR        1
`define RCS_RECEIVE_NINTH_BIT        0
`define TXS_MASTER_CLOCK_SELECT        7
`define TXS_TX9         6
`define TXS_TRANSMIT_ENABLE        5
`define TXS_SYNC        4
`define TXS_HIGH_SPEED_BAUD        2
`define TXS_SHIFT_REGISTER_EMPTY        1
`define TXS_TRANSMIT_NINTH_BIT        0

// Reset values.
`define RST_TX_CTRL     8'h02
`define RST_ZERO        8'h00

// Word lengths in bits.
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9

`endif

// >>> usart_pkg.sv
package usart_pkg;

	typedef enum logic {
		BUS_IDLE    = 1'b0,
		BUS_RD_WAIT = 1'b1
	} bus_state_t;

	typedef struct packed {
		logic       framing_error;
		logic       bit8;
		logic [7:0] data;
	} rx_entry_t;

	typedef struct packed {
		bus_state_t     bus;
		logic           hready;
		logic           wr_pend;
		logic [7:0]     idx;
		logic [31:0]    hrdata;
		logic           serial_port_enable;
		logic           rx9;
		logic           single_receive_enable;
		logic           continuous_receive_enable;
		logic           address_detect_enable;
		logic           overrun_error;
		logic           master_clock_select;
		logic           tx9;
		logic           transmit_enable;
		logic           sync;
		logic           high_speed_baud;
		logic           transmit_ninth_bit;
		logic [7:0]     irq_en;
		logic [7:0]     baud_div;
		logic [7:0]     txbuf;
		logic           txbuf_full;
		logic           transmit_flag;
		logic [8:0]     transmit_shifter;
		logic [3:0]     bits_left;
		logic           tsr_full;
		logic [7:0]     brg_cnt;
		logic           ck;
		logic           ck_oe;
		logic           dt;
		logic           dt_oe;
		logic           irq;
		rx_entry_t [1:0] fifo;
		logic [1:0]     rx_cnt;
	} state_t;

endpackage : usart_pkg

// >>> shift_slave.sv
`timescale 1ns/1ps

module shift_slave (
	input  wire logic       i_mclk,  // Core clock.
	input  wire logic       i_rst_n, // Reset, active low.
	input  wire logic       i_ck,    // Shift clock line.
	input  wire logic       i_dt,    // Shift data line.
	input  wire logic       i_dt_oe, // Data line driven by master.
	output logic      [8:0] o_word,  // Last nine bits, first one lowest.
	output logic      [7:0] o_cnt    // Bits taken so far.
);
	logic ck_r;

	// The clock runs free while enabled, so the bench frames words by count.
	always_ff @(posedge i_mclk) begin
		ck_r <= i_ck;
		if (!i_rst_n) begin
			o_word <= 9'h000;
			o_cnt  <= 8'h00;
		end else if (ck_r && !i_ck && i_dt_oe) begin
			o_word <= {i_dt, o_word[8:1]};
			o_cnt  <= o_cnt + 8'h01;
		end
	end
endmodule : shift_slave

// >>> tb.sv
`timescale 1ns/1ps
`include "usart_params.svh"

module tb;
	logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        rxv = 1'b0, rx8 = 1'b0, rxf = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [7:0]  rxd = 8'h00, cnt, base;
	logic        hready, hresp, ck, ck_oe, dt, dt_oe, irq;
	logic [8:0]  word;
	int          n_fail = 0, samples_checked = 0;

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	usart_sync_master_tx_addr_detect u_usart_sync_master_tx_addr_detect (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_bit8(rx8), .i_rx_framing_error(rxf),
		.o_ck(ck), .o_ck_oe(ck_oe), .o_dt(dt), .o_dt_oe(dt_oe), .o_irq(irq));

	shift_slave u_shift_slave (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_ck(ck), .i_dt(dt), .i_dt_oe(dt_oe),
		.o_word(word), .o_cnt(cnt));

	task automatic finish_test;
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] s);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp

	// Ready is registered, so its value read just after the edge is the sampled one.
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
			output logic [7:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		xfer(1'b1, idx, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
		logic [7:0] x;
		xfer(1'b0, idx, 8'h00, x);
		cmp(nm, {1'b0, e}, {1'b0, x});
	endtask : rd

	task automatic rxw(input logic b8, input logic [7:0] d);
		rxv <= 1'b1;
		rxd <= d;
		rx8 <= b8;
		@(posedge mclk);
		rxv <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : rxw

	task automatic bits(input logic [7:0] n, input logic [8:0] e, input string nm);
		for (int i = 0; i < 400 && cnt !== n; i++) @(posedge mclk);
		cmp(nm, e, word);
	endtask : bits

	initial begin
		#500000;
		n_fail++;
		finish_test;
	end

	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(`IDX_TX_CTRL, `RST_TX_CTRL, "tx_ctrl");
		rd(`IDX_IRQ_FLAGS, 8'h00, "flags");
		rd(`IDX_UNMAPPED, 8'h00, "unmapped");
		cmp("hresp", 9'h000, {8'h00, hresp});
		wr(`IDX_IRQ_EN, 8'h20);
		wr(`IDX_RX_CTRL, 8'hd8);
		rxw(1'b0, 8'h12);
		rd(`IDX_IRQ_FLAGS, 8'h00, "flags");
		rxw(1'b1, 8'ha5);
		cmp("irq", 9'h001, {8'h00, irq});
		rd(`IDX_RX_CTRL, 8'hd9, "rx_ctrl");
		rd(`IDX_RX_BUF, 8'ha5, "rx_buf");
		wr(`IDX_IRQ_EN, 8'h00);
		wr(`IDX_RX_CTRL, 8'hd0);
		rxw(1'b0, 8'h3c);
		rxf <= 1'b1;
		rxw(1'b1, 8'h11);
		rxf <= 1'b0;
		rxw(1'b0, 8'h22);
		cmp("irq", 9'h000, {8'h00, irq});
		rd(`IDX_RX_CTRL, 8'hd2, "rx_ctrl");
		rd(`IDX_RX_BUF, 8'h3c, "rx_buf");
		rd(`IDX_RX_CTRL, 8'hd7, "rx_ctrl");
		rd(`IDX_RX_BUF, 8'h11, "rx_buf");
		rxw(1'b0, 8'h66);
		rd(`IDX_IRQ_FLAGS, 8'h00, "flags");
		wr(`IDX_RX_CTRL, 8'hc0);
		wr(`IDX_RX_CTRL, 8'h98);
		rxw(1'b0, 8'h44);
		rd(`IDX_RX_BUF, 8'h44, "rx_buf");
		wr(`IDX_RX_CTRL, 8'h80);
		wr(`IDX_BAUD_DIV, 8'h01);
		wr(`IDX_TX_CTRL, 8'hd1);
		wr(`IDX_TX_BUF, 8'h5a);
		cmp("ck_oe", 9'h000, {8'h00, ck_oe});
		// Starting from a held generator gives no stray falling edge before bit 0.
		base = cnt;
		wr(`IDX_TX_CTRL, 8'hf1);
		wr(`IDX_TX_CTRL, 8'hf0);
		wr(`IDX_TX_BUF, 8'hc3);
		rd(`IDX_IRQ_FLAGS, 8'h00, "flags");
		bits(base + 8'h09, 9'h15a, "word1");
		rd(`IDX_IRQ_FLAGS, 8'h10, "flags");
		wr(`IDX_IRQ_FLAGS, 8'h00);
		rd(`IDX_IRQ_FLAGS, 8'h10, "flags");
		rd(`IDX_TX_CTRL, 8'hf0, "tx_ctrl");
		bits(base + 8'h12, 9'h0c3, "word2");
		repeat (8) @(posedge mclk);
		rd(`IDX_TX_CTRL, 8'hf2, "tx_ctrl");
		wr(`IDX_TX_BUF, 8'h99);
		rd(`IDX_IRQ_FLAGS, 8'h10, "flags");
		wr(`IDX_RX_CTRL, 8'h90);
		repeat (2) @(posedge mclk);
		cmp("dt_oe", 9'h000, {8'h00, dt_oe});
		cmp("ck_oe", 9'h001, {8'h00, ck_oe});
		wr(`IDX_RX_CTRL, 8'ha0);
		rxw(1'b0, 8'h0f);
		rd(`IDX_RX_CTRL, 8'h80, "rx_ctrl");
		cmp("dt_oe", 9'h001, {8'h00, dt_oe});
		rd(`IDX_RX_BUF, 8'h0f, "rx_buf");
		wr(`IDX_TX_CTRL, 8'hd0);
		repeat (2) @(posedge mclk);
		cmp("dt_oe", 9'h000, {8'h00, dt_oe});
		cmp("ck_oe", 9'h000, {8'h00, ck_oe});
		rd(`IDX_TX_CTRL, 8'hd2, "tx_ctrl");
		finish_test;
	end
endmodule : tb
